/* verilog/pmu_pkg.sv */
// Constants and types for the power management wake-up block
package pmu_pkg;

	// Register indexes; byte address is four times the index
	localparam logic [11:0] CFG_IDX       = 12'h0b5;
	localparam logic [11:0] INT_STAT_IDX  = 12'h0b6;
	localparam logic [11:0] INT_MASK_IDX  = 12'h0b7;
	localparam logic [11:0] CFG_ADDR      = {CFG_IDX[9:0], 2'b00};
	localparam logic [11:0] INT_STAT_ADDR = {INT_STAT_IDX[9:0], 2'b00};
	localparam logic [11:0] INT_MASK_ADDR = {INT_MASK_IDX[9:0], 2'b00};

	// Field positions of power_config_and_wake_flags
	localparam int unsigned B_SLEEP   = 7;
	localparam int unsigned B_SUSPEND = 6;
	localparam int unsigned B_CLEAR   = 5;
	localparam int unsigned B_GLITCH  = 4;
	localparam int unsigned B_OSCFAIL = 3;
	localparam int unsigned B_ALARM   = 2;
	localparam int unsigned B_PMATCH  = 1;
	localparam int unsigned B_CMP     = 0;
	localparam int unsigned N_EN      = 4;
	localparam int unsigned N_FLAG    = 5;

	// Reset values
	localparam logic [4:0] FLAG_RST = 5'h00;
	localparam logic [3:0] EN_RST   = 4'h0;
	localparam logic [2:0] INT_RST  = 3'h0;

	// Interrupt status bits
	localparam int unsigned IB_WAKE   = 0;
	localparam int unsigned IB_REFUSE = 1;
	localparam int unsigned IB_GLITCH = 2;
	localparam int unsigned N_INT     = 3;

	// Flag blanking after a wake from suspend, in system clocks
	localparam logic [1:0] BLANK_CYC = 2'h2;

	typedef enum logic [3:0] {
		ST_RUN   = 4'h1,
		ST_SLEEP = 4'h2,
		ST_SUSP  = 4'h4,
		ST_BLANK = 4'h8
	} pm_state_t;

endpackage : pmu_pkg

/* verilog/low_power_mode_wakeup_control.sv */
// Low-power mode entry and wake-up source control with APB registers
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps

module low_power_mode_wakeup_control (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Wake-up event sources
	input  wire logic        i_rst_glitch,
	input  wire logic        i_rtc_osc_fail,
	input  wire logic        i_rtc_alarm,
	input  wire logic        i_port_match,
	input  wire logic        i_cmp_out,
	// Power control
	output logic             o_sleep,
	output logic             o_suspend,
	output logic             o_lpo_on,
	output logic             o_wake,
	output logic             o_irq
);
	import pmu_pkg::*;

	function automatic logic hit(input logic [11:0] addr, input logic [11:0] reg_addr);
		hit = (addr == reg_addr);
	endfunction : hit

	// APB state
	logic        pready_ff;
	logic        nxt_pready;
	logic        pslverr_ff;
	logic        nxt_pslverr;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;

	// Power state
	pm_state_t   state_ff;
	pm_state_t   nxt_state;
	logic [1:0]  cnt_ff;
	logic [1:0]  nxt_cnt;
	logic [4:0]  flags_ff;
	logic [4:0]  nxt_flags;
	logic [3:0]  en_ff;
	logic [3:0]  nxt_en;
	logic        cmp_ff;
	logic        nxt_cmp;

	// Interrupts and outputs
	logic [2:0]  stat_ff;
	logic [2:0]  nxt_stat;
	logic [2:0]  mask_ff;
	logic [2:0]  nxt_mask;
	logic        irq_ff;
	logic        nxt_irq;
	logic        sleep_ff;
	logic        nxt_sleep;
	logic        susp_ff;
	logic        nxt_susp;
	logic        lpo_ff;
	logic        nxt_lpo;
	logic        wake_ff;
	logic        nxt_wake;

	// Decoded strobes
	logic        acc_done;
	logic        wr_lane0;
	logic        cfg_wr;
	logic [7:0]  wd;
	logic        lp_req;
	logic        refuse;
	logic        cmp_wake;
	logic        wake;
	logic        leave_lp;
	logic [4:0]  ev;
	logic [4:0]  rd_flags;
	logic        mapped;

	// Access is taken at the edge that sees pready high
	assign acc_done = i_psel & i_penable & pready_ff;
	assign wr_lane0 = acc_done & i_pwrite & i_pstrb[0];
	assign cfg_wr   = wr_lane0 & hit(i_paddr, CFG_ADDR);
	assign wd       = i_pwdata[7:0];
	assign lp_req   = cfg_wr & (wd[B_SLEEP] | wd[B_SUSPEND]);
	assign mapped   = hit(i_paddr, CFG_ADDR) | hit(i_paddr, INT_STAT_ADDR) | hit(i_paddr, INT_MASK_ADDR);

	// Comparator only counts as a source outside run mode, so its flag names the wake cause
	assign cmp_wake = i_cmp_out & ~cmp_ff & en_ff[B_CMP] & (state_ff != ST_RUN);
	assign ev = {i_rst_glitch, i_rtc_osc_fail, i_rtc_alarm, i_port_match, cmp_wake};

	// Glitch flag has no enable and always wakes
	assign wake = |(flags_ff & {1'b1, en_ff});

	// Hidden flags during suspend recovery
	assign rd_flags = (state_ff == ST_BLANK) ? FLAG_RST : flags_ff;

	// One wait state: pready rises in the second access cycle
	always_comb begin
		nxt_pready  = i_psel & i_penable & ~pready_ff;
		nxt_pslverr = nxt_pready & ~mapped;
		nxt_prdata  = prdata_ff;
		if (nxt_pready & ~i_pwrite) begin
			nxt_prdata = 32'h0000_0000;
			if (hit(i_paddr, CFG_ADDR)) begin
				nxt_prdata[N_FLAG-1:0] = rd_flags;
			end else if (hit(i_paddr, INT_STAT_ADDR)) begin
				nxt_prdata[N_INT-1:0] = stat_ff;
			end else if (hit(i_paddr, INT_MASK_ADDR)) begin
				nxt_prdata[N_INT-1:0] = mask_ff;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff  <= nxt_prdata;
		end
	end

	// Flags, enables and mode sequencing
	always_comb begin
		nxt_flags = flags_ff;
		nxt_en    = en_ff;
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_cmp   = i_cmp_out;
		leave_lp  = 1'b0;
		if (cfg_wr) begin
			// Every write replaces the enables, mode writes included
			nxt_en = wd[N_EN-1:0];
			if (wd[B_CLEAR]) begin
				nxt_flags = FLAG_RST;
			end
		end
		// Set wins over a clear in the same cycle
		nxt_flags = nxt_flags | ev;
		refuse = lp_req & (|nxt_flags);
		unique case (state_ff)
			ST_RUN: begin
				if (lp_req & ~refuse) begin
					nxt_state = wd[B_SLEEP] ? ST_SLEEP : ST_SUSP;
				end
			end
			ST_SLEEP: begin
				if (wake) begin
					nxt_state = ST_RUN;
					leave_lp  = 1'b1;
				end
			end
			ST_SUSP: begin
				if (wake) begin
					nxt_state = ST_BLANK;
					nxt_cnt   = BLANK_CYC - 2'h1;
					leave_lp  = 1'b1;
				end
			end
			ST_BLANK: begin
				if (cnt_ff == 2'h0) begin
					nxt_state = ST_RUN;
				end else begin
					nxt_cnt = cnt_ff - 2'h1;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_ff <= ST_RUN;
			cnt_ff   <= 2'h0;
			flags_ff <= FLAG_RST;
			en_ff    <= EN_RST;
			cmp_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			flags_ff <= nxt_flags;
			en_ff    <= nxt_en;
			cmp_ff   <= nxt_cmp;
		end
	end

	// Interrupt status, mask and registered outputs
	always_comb begin
		nxt_stat = stat_ff;
		nxt_mask = mask_ff;
		if (wr_lane0 & hit(i_paddr, INT_STAT_ADDR)) begin
			nxt_stat = stat_ff & ~i_pwdata[N_INT-1:0];
		end
		if (wr_lane0 & hit(i_paddr, INT_MASK_ADDR)) begin
			nxt_mask = i_pwdata[N_INT-1:0];
		end
		nxt_stat[IB_WAKE]   = nxt_stat[IB_WAKE] | leave_lp;
		nxt_stat[IB_REFUSE] = nxt_stat[IB_REFUSE] | refuse;
		nxt_stat[IB_GLITCH] = nxt_stat[IB_GLITCH] | i_rst_glitch;
		nxt_irq   = |(nxt_stat & nxt_mask);
		nxt_sleep = (nxt_state == ST_SLEEP);
		nxt_susp  = (nxt_state == ST_SUSP);
		// Oscillator may stop only in sleep with no flag pending
		nxt_lpo   = (|nxt_flags) | (nxt_state != ST_SLEEP);
		nxt_wake  = leave_lp;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			stat_ff  <= INT_RST;
			mask_ff  <= INT_RST;
			irq_ff   <= 1'b0;
			sleep_ff <= 1'b0;
			susp_ff  <= 1'b0;
			lpo_ff   <= 1'b1;
			wake_ff  <= 1'b0;
		end else begin
			stat_ff  <= nxt_stat;
			mask_ff  <= nxt_mask;
			irq_ff   <= nxt_irq;
			sleep_ff <= nxt_sleep;
			susp_ff  <= nxt_susp;
			lpo_ff   <= nxt_lpo;
			wake_ff  <= nxt_wake;
		end
	end

	assign o_prdata  = prdata_ff;
	assign o_pready  = pready_ff;
	assign o_pslverr = pslverr_ff;
	assign o_sleep   = sleep_ff;
	assign o_suspend = susp_ff;
	assign o_lpo_on  = lpo_ff;
	assign o_wake    = wake_ff;
	assign o_irq     = irq_ff;

	property p_sleep_entry;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state_ff == ST_RUN) && cfg_wr && wd[B_SLEEP] && !(|nxt_flags) |=> o_sleep && !o_suspend;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

	property p_susp_entry;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state_ff == ST_RUN) && cfg_wr && !wd[B_SLEEP] && wd[B_SUSPEND] && !(|nxt_flags) |=> o_suspend && !o_sleep;
	endproperty
	a_susp_entry: assert property (p_susp_entry) else $error("suspend not entered");

	property p_clear;
		@(posedge i_clk) disable iff (!i_rst_n)
		cfg_wr && wd[B_CLEAR] && (ev == 5'h00) |=> flags_ff == 5'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("flags not cleared");

	property p_glitch;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_rst_glitch |=> flags_ff[B_GLITCH];
	endproperty
	a_glitch: assert property (p_glitch) else $error("glitch flag not set");

	property p_enable;
		@(posedge i_clk) disable iff (!i_rst_n)
		cfg_wr |=> en_ff == $past(i_pwdata[3:0]);
	endproperty
	a_enable: assert property (p_enable) else $error("enables not written");

	property p_alarm;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_rtc_alarm && !i_rst_glitch |=> flags_ff[B_ALARM] ##1 flags_ff[B_ALARM] || $past(cfg_wr);
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm flag lost");

	property p_pmatch;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_port_match |=> flags_ff[B_PMATCH] && o_lpo_on;
	endproperty
	a_pmatch: assert property (p_pmatch) else $error("port match flag not set");

	property p_cmp;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state_ff == ST_SLEEP) && $rose(i_cmp_out) && en_ff[B_CMP]
		|=> flags_ff[B_CMP] ##1 (state_ff == ST_RUN) && o_wake;
	endproperty
	a_cmp: assert property (p_cmp) else $error("comparator wake missed");

	property p_refuse;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state_ff == ST_RUN) && (|flags_ff) && !(cfg_wr && wd[B_CLEAR])
		|=> (state_ff == ST_RUN) && o_lpo_on && !o_sleep && !o_suspend;
	endproperty
	a_refuse: assert property (p_refuse) else $error("entry not refused");

	property p_blank;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state_ff == ST_SUSP) && wake |=> (rd_flags == 5'h00) [*2] ##1 (state_ff == ST_RUN) && (rd_flags != 5'h00);
	endproperty
	a_blank: assert property (p_blank) else $error("suspend blanking wrong");

	property p_reset;
		@(posedge i_clk)
		!i_rst_n |=> !o_sleep && !o_suspend && (state_ff == ST_RUN) && !o_pready;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");

	property p_wake;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state_ff == ST_SLEEP) && wake && !cfg_wr |=> !o_sleep && o_wake && (($past(flags_ff) & ~flags_ff) == 5'h00);
	endproperty
	a_wake: assert property (p_wake) else $error("no wake from sleep");

endmodule : low_power_mode_wakeup_control

/* dv/tb_top.sv */
// Self-checking bench for the low-power mode and wake-up control block
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_top;
	import pmu_pkg::*;

	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic        pready, pslverr, se;
	logic [3:0]  ev = 4'h0;
	logic        cmp = 1'b0;
	logic        o_sleep, o_suspend, o_lpo_on, o_wake, o_irq;
	int          err_count = 0, checks = 0;

	always #20 i_clk = ~i_clk;

	low_power_mode_wakeup_control i_dut (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_rst_glitch(ev[3]), .i_rtc_osc_fail(ev[2]), .i_rtc_alarm(ev[1]),
		.i_port_match(ev[0]), .i_cmp_out(cmp), .o_sleep(o_sleep), .o_suspend(o_suspend),
		.o_lpo_on(o_lpo_on), .o_wake(o_wake), .o_irq(o_irq)
	);

	// Request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(negedge i_clk);
	endtask : apb

	// Returns at the edge that takes the event, so a wake pulse is still ahead
	task pulse(input logic [3:0] v);
		@(posedge i_clk);
		ev <= v;
		@(posedge i_clk);
		ev <= 4'h0;
	endtask : pulse

	// Bounded wait for the one-cycle wake pulse
	task wait_wake(output logic seen);
		seen = 1'b0;
		repeat (8) begin
			@(negedge i_clk);
			if (o_wake === 1'b1) seen = 1'b1;
		end
	endtask : wait_wake

	task test_done;
		if (err_count == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : test_done

	// Event input pattern beside the flag byte it should leave behind
	typedef struct { logic [3:0] ev; logic [7:0] flags; } row_t;
	row_t rows [4] = '{'{4'h8, 8'h10}, '{4'h4, 8'h08}, '{4'h2, 8'h04}, '{4'h1, 8'h02}};
	logic seen;

	initial begin
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(negedge i_clk);
		`CHK({o_sleep, o_suspend, o_lpo_on, o_irq}, 4'b0010)
		apb(1'b0, CFG_ADDR, 32'h0);
		`CHK(rd, 32'h0000_0000)
		foreach (rows[k]) begin
			apb(1'b1, CFG_ADDR, 32'h0000_0020);
			pulse(rows[k].ev);
			apb(1'b0, CFG_ADDR, 32'h0);
			`CHK(rd[7:0], rows[k].flags)
			apb(1'b1, CFG_ADDR, 32'h0000_0020);
			apb(1'b0, CFG_ADDR, 32'h0);
			`CHK(rd[7:0], 8'h00)
		end
		apb(1'b0, 12'h000, 32'h0);
		`CHK({se, rd}, {1'b1, 32'h0000_0000})
		// Sleep with only port match enabled, then wake on it
		apb(1'b1, CFG_ADDR, 32'h0000_0082);
		`CHK({o_sleep, o_lpo_on}, 2'b10)
		pulse(4'h1);
		wait_wake(seen);
		`CHK({seen, o_sleep}, 2'b10)
		apb(1'b0, CFG_ADDR, 32'h0);
		`CHK(rd[7:0], 8'h02)
		// A set flag must block entry and keep the oscillator on
		apb(1'b1, CFG_ADDR, 32'h0000_0080);
		`CHK({o_sleep, o_suspend, o_lpo_on}, 3'b001)
		apb(1'b0, INT_STAT_ADDR, 32'h0);
		`CHK(rd[IB_REFUSE], 1'b1)
		`CHK(o_irq, 1'b0)
		apb(1'b1, INT_MASK_ADDR, 32'h0000_0007);
		repeat (2) @(negedge i_clk);
		`CHK(o_irq, 1'b1)
		apb(1'b1, INT_STAT_ADDR, 32'h0000_0007);
		repeat (2) @(negedge i_clk);
		`CHK(o_irq, 1'b0)
		apb(1'b0, INT_STAT_ADDR, 32'h0);
		`CHK(rd[2:0], 3'h0)
		// Enables replaced by the mode write: port match must not wake
		apb(1'b1, CFG_ADDR, 32'h0000_0020);
		apb(1'b1, CFG_ADDR, 32'h0000_00c0);
		`CHK({o_sleep, o_suspend}, 2'b10)
		pulse(4'h1);
		wait_wake(seen);
		`CHK({seen, o_sleep}, 2'b01)
		pulse(4'h8);
		wait_wake(seen);
		`CHK({seen, o_sleep}, 2'b10)
		// Suspend, woken by a comparator rising edge
		apb(1'b1, CFG_ADDR, 32'h0000_0020);
		apb(1'b1, CFG_ADDR, 32'h0000_0041);
		`CHK({o_suspend, o_lpo_on}, 2'b11)
		@(posedge i_clk);
		cmp <= 1'b1;
		wait_wake(seen);
		`CHK({seen, o_suspend}, 2'b10)
		apb(1'b0, CFG_ADDR, 32'h0);
		`CHK(rd[7:0], 8'h01)
		// Sleep, woken by a comparator rising edge
		@(posedge i_clk);
		cmp <= 1'b0;
		apb(1'b1, CFG_ADDR, 32'h0000_0020);
		apb(1'b1, CFG_ADDR, 32'h0000_0081);
		`CHK(o_sleep, 1'b1)
		@(posedge i_clk);
		cmp <= 1'b1;
		wait_wake(seen);
		`CHK({seen, o_sleep}, 2'b10)
		apb(1'b0, CFG_ADDR, 32'h0);
		`CHK(rd[7:0], 8'h01)
		// Reset in mid-run while asleep
		apb(1'b1, CFG_ADDR, 32'h0000_0020);
		apb(1'b1, CFG_ADDR, 32'h0000_0080);
		`CHK(o_sleep, 1'b1)
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(negedge i_clk);
		`CHK({o_sleep, o_suspend, o_lpo_on, o_irq}, 4'b0010)
		apb(1'b0, CFG_ADDR, 32'h0);
		`CHK(rd, 32'h0000_0000)
		test_done();
	end

	initial begin
		#200000;
		err_count++;
		test_done();
	end
endmodule : tb_top
